// ==== verilog/hsc_pkg.sv ====
/*
  Shared constants for the hall sensor configuration block: register map,
  field positions, reset values, serial framing and refresh timing.
  Assumes a 10 MHz system clock.
*/
package hsc_pkg;
  // timing
  localparam int unsigned CLK_HZ       = 10000000;
  localparam int unsigned RATE_W14_HZ  = 3000;
  localparam int unsigned RATE_W15_HZ  = 1500;
  localparam int unsigned RATE_W16_HZ  = 750;
  localparam int unsigned RATE_W16S_HZ = 375;
  localparam int unsigned PER_W14      = CLK_HZ / RATE_W14_HZ;
  localparam int unsigned PER_W15      = CLK_HZ / RATE_W15_HZ;
  localparam int unsigned PER_W16      = CLK_HZ / RATE_W16_HZ;
  localparam int unsigned PER_W16S     = CLK_HZ / RATE_W16S_HZ;
  // register numbers and reset values
  localparam logic [1:0] REG_SETUP   = 2'h0;
  localparam logic [1:0] REG_OPTIONS = 2'h1;
  localparam logic [1:0] REG_THERMAL = 2'h2;
  localparam logic [7:0] SETUP_RST   = 8'h00;
  localparam logic [7:0] OPTIONS_RST = 8'h00;
  localparam logic [7:0] THERMAL_RST = 8'h08;
  localparam logic [7:0] THERMAL_MSK = 8'hFC;
  // field positions
  localparam int CHAN_LSB = 0;
  localparam int SPAN_LSB = 2;
  localparam int WID_LSB  = 4;
  localparam int AXIS_LSB = 6;
  localparam int READY_ON_SO_BIT = 0;
  localparam int IDLE_DRIVE_BIT  = 1;
  localparam int LOW_CUR_BIT     = 2;
  localparam int BIAS_REV_BIT    = 3;
  localparam int DBL_CLK_BIT     = 4;
  localparam int PLUS_THIRD_BIT  = 5;
  localparam int TIMES_TEN_BIT   = 7;
  localparam int SLOPE_LSB       = 3;
  // serial framing
  localparam logic [4:0] WORD_BITS  = 5'h10;
  localparam logic [4:0] CMD_BITS   = 5'h08;
  localparam int WR_BIT     = 13;
  localparam int RD_BIT     = 12;
  localparam int REGNUM_LSB = 8;
  // channel codes, kept here so the mapping is one edit
  localparam logic [1:0] CHAN_X = 2'h0;
  localparam logic [1:0] CHAN_Y = 2'h1;
  localparam logic [1:0] CHAN_Z = 2'h2;
  localparam logic [1:0] CHAN_T = 2'h3;
  // sample masks per adc width code
  localparam logic [15:0] MASK_W14 = 16'hFFFC;
  localparam logic [15:0] MASK_W15 = 16'hFFFE;
  localparam logic [15:0] MASK_W16 = 16'hFFFF;
  // span in mT per gain code, extension factors
  localparam logic [15:0] SPAN0_MT = 16'h0064;
  localparam logic [15:0] SPAN1_MT = 16'h012C;
  localparam logic [15:0] SPAN2_MT = 16'h03E8;
  localparam logic [15:0] SPAN3_MT = 16'h0BB8;
  localparam logic [23:0] EXT_NUM  = 24'h00014D;
  localparam logic [23:0] EXT_DEN  = 24'h0003E8;
  localparam logic [23:0] TEN_ADD  = 24'h000009;
  // sample stream
  localparam int STREAM_W   = 18;
  localparam int FIFO_DEPTH = 4;
  typedef enum logic [1:0] {
    AXIS_SCAN = 2'b00,
    AXIS_X    = 2'b01,
    AXIS_Y    = 2'b10,
    AXIS_Z    = 2'b11
  } hsc_axis_type;
  typedef enum logic {
    LINK_IDLE  = 1'b0,
    LINK_FRAME = 1'b1
  } hsc_link_type;
endpackage

// ==== verilog/hsc_stream_if.sv ====
/*
  Valid/ready sample stream between the pacer, the fifo and the top.
  Assumes one clock domain on both sides.
*/
`timescale 1ns/100ps
interface hsc_stream_if #(parameter int W = 18);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ==== verilog/hsc_fifo.sv ====
/*
  Small flip-flop fifo with valid/ready on both sides.
  Assumes a synchronous active low reset; depth is a power of two.
*/
`timescale 1ns/100ps
module hsc_fifo #(
  parameter int W     = 18,
  parameter int DEPTH = 4
) (
  input  wire logic  clk_sys,
  input  wire logic  reset_n,
  hsc_stream_if.snk  fill,
  hsc_stream_if.src  drain
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0]   cnt_r;
  logic          push;
  logic          pop;

  // honest flags straight from the count
  assign fill.ready  = (cnt_r != FULL);
  assign drain.valid = (cnt_r != '0);
  assign drain.data  = mem_r[rd_r];
  assign push = fill.valid & fill.ready;
  assign pop  = drain.valid & drain.ready;

  // storage, written by index
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_r[wr_r] <= fill.data;
    end
  end

  // pointers and occupancy
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wr_r <= wr_r + 1'b1;
      if (pop) rd_r <= rd_r + 1'b1;
      if (push && !pop) cnt_r <= cnt_r + 1'b1;
      else if (pop && !push) cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule

// ==== verilog/hsc_adc_pacer.sv ====
/*
  Refresh pacer: picks the channel to convert at the adc refresh rate,
  formats the word and offers it on a stream.
  Assumes raw codes from the analog front end on the same clock.
*/
`timescale 1ns/100ps
module hsc_adc_pacer #(
  parameter int unsigned P_W14  = hsc_pkg::PER_W14,
  parameter int unsigned P_W15  = hsc_pkg::PER_W15,
  parameter int unsigned P_W16  = hsc_pkg::PER_W16,
  parameter int unsigned P_W16S = hsc_pkg::PER_W16S
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic [1:0]  width_code,
  input  wire logic [1:0]  axis_choice,
  input  wire logic        bias_reversal,
  input  wire logic [15:0] raw_x,
  input  wire logic [15:0] raw_y,
  input  wire logic [15:0] raw_z,
  input  wire logic [15:0] raw_temp,
  output logic      [1:0]  axis_sel_r,
  hsc_stream_if.src        out
);
  logic [15:0] count_r;
  logic [15:0] period;
  logic [15:0] mask;
  logic [1:0]  step_r;
  logic [1:0]  chan;
  logic [15:0] raw;
  logic        tick;
  logic        valid_r;
  logic [17:0] data_r;

  assign out.valid = valid_r;
  assign out.data  = data_r;
  assign tick = (count_r == 16'h0000);

  // refresh period and low bit mask per width code
  always_comb begin
    case (width_code)
      2'b00:   begin period = 16'(P_W14);  mask = hsc_pkg::MASK_W14; end
      2'b01:   begin period = 16'(P_W15);  mask = hsc_pkg::MASK_W15; end
      2'b10:   begin period = 16'(P_W16);  mask = hsc_pkg::MASK_W16; end
      default: begin period = 16'(P_W16S); mask = hsc_pkg::MASK_W16; end
    endcase
  end

  // scan all three axes plus temperature, or one axis then temperature
  always_comb begin
    if (axis_choice == hsc_pkg::AXIS_SCAN) chan = step_r;
    else if (step_r[0]) chan = hsc_pkg::CHAN_T;
    else chan = axis_choice - 2'h1;
    case (chan)
      hsc_pkg::CHAN_X: raw = raw_x;
      hsc_pkg::CHAN_Y: raw = raw_y;
      hsc_pkg::CHAN_Z: raw = raw_z;
      default:         raw = raw_temp;
    endcase
  end

  // period counter keeps running while the stream stalls
  always_ff @(posedge clk_sys) begin
    if (!reset_n) count_r <= 16'h0000;
    else if (tick) count_r <= period - 16'h0001;
    else count_r <= count_r - 16'h0001;
  end

  // capture; a tick that meets a stalled word is skipped, not queued
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      valid_r    <= 1'b0;
      data_r     <= '0;
      step_r     <= 2'h0;
      axis_sel_r <= 2'h0;
    end else begin
      if (valid_r && out.ready) valid_r <= 1'b0;
      if (tick && !(valid_r && !out.ready)) begin
        valid_r    <= 1'b1;
        step_r     <= step_r + 2'h1;
        axis_sel_r <= chan;
        // field words mirrored about mid-scale when bias is reversed
        if (bias_reversal && chan != hsc_pkg::CHAN_T) data_r <= {chan, ~raw & mask};
        else data_r <= {chan, raw & mask};
      end
    end
  end
endmodule

// ==== verilog/hsc_sensor_cfg.sv ====
/*
  Hall sensor configuration and serial readout core: three configuration
  registers written and read back over a 4-wire serial port, per-channel
  output buffers, the ready flag and the serial-out pin drive.
  Assumes cs, sck and mosi are asynchronous pins, sck far slower than
  clk_sys, sck idle low, data taken on the sck rising edge.
*/
`timescale 1ns/100ps
module hsc_sensor_cfg #(
  parameter int unsigned P_W14  = hsc_pkg::PER_W14,
  parameter int unsigned P_W15  = hsc_pkg::PER_W15,
  parameter int unsigned P_W16  = hsc_pkg::PER_W16,
  parameter int unsigned P_W16S = hsc_pkg::PER_W16S
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_sck,
  input  wire logic        spi_mosi,
  output logic             spi_miso_o,
  output logic             spi_miso_oe,
  output logic             ready_pin_o,
  output logic             ready_pin_oe,
  input  wire logic [15:0] raw_x,
  input  wire logic [15:0] raw_y,
  input  wire logic [15:0] raw_z,
  input  wire logic [15:0] raw_temp,
  output logic      [1:0]  hall_axis_sel,
  output logic      [1:0]  gain_span_code,
  output logic      [1:0]  adc_bit_width,
  output logic      [15:0] effective_span_mt,
  output logic             low_current_mode,
  output logic             bias_reversal,
  output logic             double_analog_clock,
  output logic      [3:0]  thermal_gain_slope
);
  // configuration registers
  logic [7:0]  setup_r;
  logic [7:0]  options_r;
  logic [7:0]  thermal_r;
  // pin synchronisers; stage one is read only by stage two
  logic [2:0]  cs_sync_r;
  logic [2:0]  sck_sync_r;
  logic [1:0]  mosi_sync_r;
  logic        cs_fall;
  logic        cs_rise;
  logic        sck_rise;
  logic        sck_fall;
  logic        cs_low;
  // serial engine
  hsc_pkg::hsc_link_type state_r;
  hsc_pkg::hsc_link_type state_nxt;
  logic [4:0]  bit_cnt_r;
  logic [15:0] rx_r;
  logic [15:0] rx_nxt;
  logic [15:0] tx_r;
  logic [7:0]  readback;
  logic        new_sample_flag_r;
  logic        spi_miso_o_r;
  logic        spi_miso_oe_r;
  logic        ready_pin_o_r;
  logic        ready_pin_oe_r;
  logic [15:0] span_r;
  logic [15:0] span_base;
  logic [23:0] span_sum;
  // per-channel output buffers
  logic [15:0] chan_buf_r [4];
  logic        pop;
  logic [1:0]  pop_chan;
  logic [1:0]  out_chan;

  hsc_stream_if #(.W(hsc_pkg::STREAM_W)) pace_s ();
  hsc_stream_if #(.W(hsc_pkg::STREAM_W)) buf_s ();

  // field decoding
  assign out_chan = setup_r[hsc_pkg::CHAN_LSB +: 2];

  // conversion pacing and formatting
  hsc_adc_pacer #(
    .P_W14  (P_W14),
    .P_W15  (P_W15),
    .P_W16  (P_W16),
    .P_W16S (P_W16S)
  ) u_pacer (
    .clk_sys       (clk_sys),
    .reset_n       (reset_n),
    .width_code    (setup_r[hsc_pkg::WID_LSB +: 2]),
    .axis_choice   (setup_r[hsc_pkg::AXIS_LSB +: 2]),
    .bias_reversal (options_r[hsc_pkg::BIAS_REV_BIT]),
    .raw_x         (raw_x),
    .raw_y         (raw_y),
    .raw_z         (raw_z),
    .raw_temp      (raw_temp),
    .axis_sel_r    (hall_axis_sel),
    .out           (pace_s.src)
  );

  // sample queue between the pacer and the output buffers
  hsc_fifo #(
    .W     (hsc_pkg::STREAM_W),
    .DEPTH (hsc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .fill    (pace_s.snk),
    .drain   (buf_s.src)
  );

  // drain stalls during a frame so the word being shifted stays put
  assign buf_s.ready = !cs_low;
  assign pop         = buf_s.valid & buf_s.ready;
  assign pop_chan    = buf_s.data[17:16];

  // pin synchronisers, third stage only for edge finding
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cs_sync_r   <= 3'h7;
      sck_sync_r  <= 3'h0;
      mosi_sync_r <= 2'h0;
    end else begin
      cs_sync_r   <= {cs_sync_r[1:0], spi_cs_n};
      sck_sync_r  <= {sck_sync_r[1:0], spi_sck};
      mosi_sync_r <= {mosi_sync_r[0], spi_mosi};
    end
  end

  assign cs_low   = !cs_sync_r[1];
  assign cs_fall  = cs_sync_r[2] & !cs_sync_r[1];
  assign cs_rise  = !cs_sync_r[2] & cs_sync_r[1];
  assign sck_rise = cs_low & !sck_sync_r[2] & sck_sync_r[1];
  assign sck_fall = cs_low & sck_sync_r[2] & !sck_sync_r[1];
  assign rx_nxt   = {rx_r[14:0], mosi_sync_r[1]};

  // buffer update per channel entry
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_chan
      always_ff @(posedge clk_sys) begin
        if (!reset_n) chan_buf_r[gi] <= 16'h0000;
        else if (pop && pop_chan == 2'(gi)) chan_buf_r[gi] <= buf_s.data[15:0];
      end
    end
  endgenerate

  // frame state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      hsc_pkg::LINK_IDLE:  if (cs_fall) state_nxt = hsc_pkg::LINK_FRAME;
      hsc_pkg::LINK_FRAME: if (cs_rise) state_nxt = hsc_pkg::LINK_IDLE;
      default:             state_nxt = hsc_pkg::LINK_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) state_r <= hsc_pkg::LINK_IDLE;
    else state_r <= state_nxt;
  end

  // bit counter saturates so overlong frames are not written
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      bit_cnt_r <= 5'h00;
      rx_r      <= 16'h0000;
    end else if (cs_fall) begin
      bit_cnt_r <= 5'h00;
      rx_r      <= 16'h0000;
    end else if (sck_rise && state_r == hsc_pkg::LINK_FRAME) begin
      rx_r <= rx_nxt;
      if (bit_cnt_r != 5'h1F) bit_cnt_r <= bit_cnt_r + 5'h01;
    end
  end

  // read-back value; thermal bits 1:0 read as zero
  always_comb begin
    case (rx_nxt[1:0])
      hsc_pkg::REG_SETUP:   readback = setup_r;
      hsc_pkg::REG_OPTIONS: readback = options_r;
      hsc_pkg::REG_THERMAL: readback = thermal_r & hsc_pkg::THERMAL_MSK;
      default:              readback = 8'h00;
    endcase
  end

  // outgoing word: selected channel at cs fall, msb first
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      tx_r <= 16'h0000;
    end else if (cs_fall) begin
      tx_r <= chan_buf_r[out_chan];
    end else if (sck_rise && state_r == hsc_pkg::LINK_FRAME &&
                 bit_cnt_r == hsc_pkg::CMD_BITS - 5'h01 &&
                 rx_nxt[hsc_pkg::RD_BIT - 8]) begin
      // after the command byte the low byte becomes the register value
      tx_r <= {tx_r[15], readback, 7'h00};
    end else if (sck_fall) begin
      tx_r <= {tx_r[14:0], 1'b0};
    end
  end

  // register writes land at frame end, only for complete words
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      setup_r   <= hsc_pkg::SETUP_RST;
      options_r <= hsc_pkg::OPTIONS_RST;
      thermal_r <= hsc_pkg::THERMAL_RST;
    end else if (cs_rise && state_r == hsc_pkg::LINK_FRAME &&
                 bit_cnt_r == hsc_pkg::WORD_BITS && rx_r[hsc_pkg::WR_BIT]) begin
      // reserved bits are stored as written; zeros are up to the master
      case (rx_r[hsc_pkg::REGNUM_LSB +: 2])
        hsc_pkg::REG_SETUP:   setup_r   <= rx_r[7:0];
        hsc_pkg::REG_OPTIONS: options_r <= rx_r[7:0];
        hsc_pkg::REG_THERMAL: thermal_r <= rx_r[7:0];
        default:              setup_r   <= setup_r;
      endcase
    end
  end

  // ready flag: new sample in selected buffer sets, cs fall clears; set wins
  always_ff @(posedge clk_sys) begin
    if (!reset_n) new_sample_flag_r <= 1'b0;
    else if (pop && pop_chan == out_chan) new_sample_flag_r <= 1'b1;
    else if (cs_fall) new_sample_flag_r <= 1'b0;
  end

  // serial-out drive: data in frame, ready or low with idle drive on, released otherwise
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      spi_miso_o_r  <= 1'b0;
      spi_miso_oe_r <= 1'b0;
    end else if (cs_low) begin
      spi_miso_o_r  <= tx_r[15];
      spi_miso_oe_r <= 1'b1;
    end else if (options_r[hsc_pkg::IDLE_DRIVE_BIT]) begin
      // ready only shows if idle drive is on, which the master ensures
      spi_miso_o_r  <= options_r[hsc_pkg::READY_ON_SO_BIT] & new_sample_flag_r;
      spi_miso_oe_r <= 1'b1;
    end else begin
      spi_miso_o_r  <= 1'b0;
      spi_miso_oe_r <= 1'b0;
    end
  end

  // dedicated ready pin floats once ready is routed to serial out
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ready_pin_o_r  <= 1'b0;
      ready_pin_oe_r <= 1'b1;
    end else begin
      ready_pin_o_r  <= new_sample_flag_r;
      ready_pin_oe_r <= !options_r[hsc_pkg::READY_ON_SO_BIT];
    end
  end

  assign spi_miso_o   = spi_miso_o_r;
  assign spi_miso_oe  = spi_miso_oe_r;
  assign ready_pin_o  = ready_pin_o_r;
  assign ready_pin_oe = ready_pin_oe_r;

  // span in mT; integer division trades a fraction of a mT for simplicity
  always_comb begin
    case (setup_r[hsc_pkg::SPAN_LSB +: 2])
      2'b00:   span_base = hsc_pkg::SPAN0_MT;
      2'b01:   span_base = hsc_pkg::SPAN1_MT;
      2'b10:   span_base = hsc_pkg::SPAN2_MT;
      default: span_base = hsc_pkg::SPAN3_MT;
    endcase
    span_sum = {8'h00, span_base};
    if (options_r[hsc_pkg::PLUS_THIRD_BIT]) begin
      span_sum = span_sum + ({8'h00, span_base} * hsc_pkg::EXT_NUM) / hsc_pkg::EXT_DEN;
    end
    if (options_r[hsc_pkg::TIMES_TEN_BIT]) begin
      span_sum = span_sum + {8'h00, span_base} * hsc_pkg::TEN_ADD;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) span_r <= hsc_pkg::SPAN0_MT;
    else span_r <= span_sum[15:0];
  end

  // analog controls straight from register flops
  assign gain_span_code      = setup_r[hsc_pkg::SPAN_LSB +: 2];
  assign adc_bit_width       = setup_r[hsc_pkg::WID_LSB +: 2];
  assign effective_span_mt   = span_r;
  assign low_current_mode    = options_r[hsc_pkg::LOW_CUR_BIT];
  assign bias_reversal       = options_r[hsc_pkg::BIAS_REV_BIT];
  assign double_analog_clock = options_r[hsc_pkg::DBL_CLK_BIT];
  assign thermal_gain_slope  = thermal_r[hsc_pkg::SLOPE_LSB +: 4];
endmodule

// ==== dv/hsc_spi_master.sv ====
/*
  Serial master model: frames of up to 16 bits, msb first, 800 ns sck.
  Assumes a 100 ns bench clock; sck stands low outside frames.
*/
`timescale 1ns/100ps
module hsc_spi_master (
  input  wire logic clk_sys,
  output logic      spi_cs_n,
  output logic      spi_sck,
  output logic      spi_mosi,
  input  wire logic spi_miso_o,
  input  wire logic spi_miso_oe
);
  logic miso_last;
  logic miso_w;
  // a released line shows the inverse of its last level, never a kind value
  always @(posedge clk_sys) if (spi_miso_oe) miso_last <= spi_miso_o;
  assign miso_w = spi_miso_oe ? spi_miso_o : ~miso_last;
  initial begin
    spi_cs_n = 1'b1;
    spi_sck = 1'b0;
    spi_mosi = 1'b0;
  end
  // one frame; read bit taken late in the high phase, well after it settles
  task automatic xfer(input logic [15:0] w, input int nbits, output logic [15:0] r);
    r = 16'h0000;
    @(negedge clk_sys);
    spi_cs_n = 1'b0;
    repeat (6) @(negedge clk_sys);
    for (int i = 0; i < nbits; i++) begin
      spi_mosi = w[15-i];
      repeat (4) @(negedge clk_sys);
      spi_sck = 1'b1;
      repeat (4) @(negedge clk_sys);
      r = {r[14:0], miso_w};
      spi_sck = 1'b0;
    end
    repeat (4) @(negedge clk_sys);
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    repeat (6) @(negedge clk_sys);
  endtask
endmodule

// ==== dv/hsc_sensor_cfg_props.sv ====
/*
  Port checks for the sensor configuration core.
  Assumes sck idles low and is slow against clk_sys; bound below.
*/
`timescale 1ns/100ps
module hsc_sensor_cfg_props (
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        spi_cs_n,
  input wire logic        spi_sck,
  input wire logic        spi_miso_o,
  input wire logic        spi_miso_oe,
  input wire logic        ready_pin_o,
  input wire logic        ready_pin_oe,
  input wire logic [1:0]  gain_span_code,
  input wire logic [1:0]  adc_bit_width,
  input wire logic [15:0] effective_span_mt,
  input wire logic        low_current_mode,
  input wire logic        bias_reversal,
  input wire logic        double_analog_clock,
  input wire logic [3:0]  thermal_gain_slope
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // chip select settled past the pin synchronisers
  sequence s_frame_settled;
    !spi_cs_n [*4];
  endsequence
  sequence s_idle_settled;
    spi_cs_n [*6];
  endsequence
  // base span, plus a third, plus nine times base
  function automatic logic span_ok(logic [1:0] g, logic [15:0] s);
    logic [23:0] b;
    logic [23:0] t;
    b = {8'h00, g == 2'h0 ? hsc_pkg::SPAN0_MT : g == 2'h1 ? hsc_pkg::SPAN1_MT :
         g == 2'h2 ? hsc_pkg::SPAN2_MT : hsc_pkg::SPAN3_MT};
    t = b * hsc_pkg::EXT_NUM / hsc_pkg::EXT_DEN;
    return {8'h00, s} == b || {8'h00, s} == b + t || {8'h00, s} == b * 24'h00000A ||
           {8'h00, s} == b * 24'h00000A + t;
  endfunction
  a_span_formula: assert property ($stable(gain_span_code) |->
    span_ok(gain_span_code, effective_span_mt)) else $error("span off its formula");
  a_frame_drives: assert property (s_frame_settled |-> spi_miso_oe)
    else $error("serial out not driven in frame");
  a_idle_zero: assert property (s_idle_settled ##0 (ready_pin_oe && spi_miso_oe)
    |-> !spi_miso_o) else $error("idle serial out not low");
  a_ready_hold: assert property (s_frame_settled ##0 !ready_pin_o |=> !ready_pin_o)
    else $error("ready set during frame");
  a_ready_clear: assert property (s_frame_settled ##1 !spi_cs_n |-> !ready_pin_o)
    else $error("ready not cleared in frame");
  a_cfg_frozen: assert property (s_frame_settled |=> $stable({gain_span_code,
    adc_bit_width, low_current_mode, bias_reversal, double_analog_clock,
    thermal_gain_slope})) else $error("config changed inside frame");
  a_route_frozen: assert property (s_frame_settled |=> $stable(ready_pin_oe))
    else $error("ready routing changed inside frame");
  a_miso_hold: assert property ((!spi_cs_n && spi_sck) [*4] |=> $stable(spi_miso_o))
    else $error("serial out moved while sck high");
  a_reset_values: assert property ($rose(reset_n) |-> thermal_gain_slope == 4'h1 &&
    adc_bit_width == 2'h0 && effective_span_mt == hsc_pkg::SPAN0_MT && ready_pin_oe &&
    !spi_miso_oe) else $error("bad values after reset");
endmodule
bind hsc_sensor_cfg hsc_sensor_cfg_props i_hsc_sensor_cfg_props (.clk_sys, .reset_n,
  .spi_cs_n, .spi_sck, .spi_miso_o, .spi_miso_oe, .ready_pin_o, .ready_pin_oe,
  .gain_span_code, .adc_bit_width, .effective_span_mt, .low_current_mode,
  .bias_reversal, .double_analog_clock, .thermal_gain_slope);

// ==== dv/hsc_sensor_cfg_tb_top.sv ====
/*
  Bench for the sensor configuration core: registers, span, sample words,
  ready routing, idle drive and axis scanning.
  Assumes the master model and the bound checker are compiled first.
*/
`timescale 1ns/100ps
module hsc_sensor_cfg_tb_top;
  localparam int unsigned PW = 20;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic        spi_cs_n, spi_sck, spi_mosi, spi_miso_o, spi_miso_oe;
  logic        ready_pin_o, ready_pin_oe, low_current_mode, bias_reversal, double_analog_clock;
  logic [15:0] raw_x = 16'hA5A7, raw_y = 16'h3C3D, raw_z = 16'h0F0F, raw_temp = 16'h8001;
  logic [15:0] effective_span_mt, rw;
  logic [3:0]  thermal_gain_slope;
  logic [1:0]  hall_axis_sel, gain_span_code, adc_bit_width;
  int          err_total = 0;
  int          comparisons = 0;
  int          hits;
  // 10 MHz system clock
  always #50 clk_sys = ~clk_sys;
  // short refresh periods keep the run brief
  hsc_sensor_cfg #(.P_W14(PW), .P_W15(2*PW), .P_W16(4*PW), .P_W16S(8*PW)) i_hsc_sensor_cfg (
    .clk_sys, .reset_n, .spi_cs_n, .spi_sck, .spi_mosi, .spi_miso_o, .spi_miso_oe,
    .ready_pin_o, .ready_pin_oe, .raw_x, .raw_y, .raw_z, .raw_temp, .hall_axis_sel,
    .gain_span_code, .adc_bit_width, .effective_span_mt, .low_current_mode,
    .bias_reversal, .double_analog_clock, .thermal_gain_slope);
  hsc_spi_master i_hsc_spi_master (.clk_sys, .spi_cs_n, .spi_sck, .spi_mosi,
    .spi_miso_o, .spi_miso_oe);
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [1:0] rg, input logic [7:0] v);
    i_hsc_spi_master.xfer({4'h2, 2'h3, rg, v}, 16, rw);
  endtask
  task automatic rd(input logic [1:0] rg, input logic [7:0] exp);
    i_hsc_spi_master.xfer({4'h1, 2'h3, rg, 8'h00}, 16, rw);
    check("readback", {8'h00, exp}, {8'h00, rw[7:0]});
  endtask
  // new settings need a few refresh periods before the buffers hold them
  task automatic sample(input logic [7:0] opt, input logic [7:0] su, input logic [15:0] exp);
    wr(2'h1, opt);
    wr(2'h0, su);
    repeat (1000) @(negedge clk_sys);
    check("width code", {14'h0, su[5:4]}, {14'h0, adc_bit_width});
    i_hsc_spi_master.xfer(16'h0000, 16, rw);
    check("sample word", exp, rw);
  endtask
  task automatic span_sweep();
    logic [23:0] b;
    logic [23:0] e;
    for (int g = 0; g < 4; g++) begin
      wr(2'h0, 8'(g << 2));
      b = {8'h00, g == 0 ? hsc_pkg::SPAN0_MT : g == 1 ? hsc_pkg::SPAN1_MT :
           g == 2 ? hsc_pkg::SPAN2_MT : hsc_pkg::SPAN3_MT};
      for (int o = 0; o < 4; o++) begin
        wr(2'h1, {o[1], 1'b0, o[0], 5'h00});
        e = b + (o[0] ? b * 24'h00014D / 24'h0003E8 : 24'h0) + (o[1] ? b * 24'h000009 : 24'h0);
        check("span", e[15:0], effective_span_mt);
        check("gain code", 16'(g), {14'h0, gain_span_code});
      end
    end
  endtask
  // single axis: the two other field axes must never be converted
  task automatic axis_only(input logic [7:0] su, input logic [1:0] c0, input logic [1:0] c1);
    wr(2'h0, su);
    hits = 0;
    repeat (400) @(negedge clk_sys);
    repeat (400) begin
      @(negedge clk_sys);
      if (hall_axis_sel === c0 || hall_axis_sel === c1) hits++;
    end
    check("other axis converted", 16'h0000, 16'(hits));
  endtask
  // main sequence
  initial begin
    repeat (3) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    check("slope at reset", 16'h0001, {12'h0, thermal_gain_slope});
    rd(2'h0, 8'h00);
    rd(2'h1, 8'h00);
    rd(2'h2, 8'h08);
    wr(2'h2, 8'h7B);
    check("slope", 16'h000F, {12'h0, thermal_gain_slope});
    rd(2'h2, 8'h78);
    wr(2'h1, 8'h1C);
    check("option outputs", 16'h0007, {13'h0, low_current_mode, bias_reversal,
      double_analog_clock});
    span_sweep();
    wr(2'h0, 8'h15);
    i_hsc_spi_master.xfer({4'h0, 2'h3, 2'h0, 8'hFF}, 16, rw);
    i_hsc_spi_master.xfer({4'h2, 2'h3, 2'h0, 8'hFF}, 15, rw);
    rd(2'h0, 8'h15);
    wr(2'h3, 8'hFF);
    rd(2'h3, 8'h00);
    sample(8'h00, 8'h00, raw_x & hsc_pkg::MASK_W14);
    sample(8'h08, 8'h11, ~raw_y & hsc_pkg::MASK_W15);
    sample(8'h08, 8'h23, raw_temp);
    sample(8'h00, 8'hF2, raw_z);
    repeat (1000) @(negedge clk_sys);
    check("ready pin", 16'h0003, {14'h0, ready_pin_oe, ready_pin_o});
    wr(2'h1, 8'h03);
    repeat (1000) @(negedge clk_sys);
    check("ready on serial out", 16'h0003, {13'h0, ready_pin_oe, spi_miso_oe, spi_miso_o});
    wr(2'h1, 8'h00);
    check("idle tri-state", 16'h0000, {15'h0, spi_miso_oe});
    wr(2'h1, 8'h02);
    check("idle drive low", 16'h0006, {13'h0, ready_pin_oe, spi_miso_oe, spi_miso_o});
    axis_only(8'h40, hsc_pkg::CHAN_Y, hsc_pkg::CHAN_Z);
    axis_only(8'h80, hsc_pkg::CHAN_X, hsc_pkg::CHAN_Z);
    wr(2'h0, 8'h00);
    hits = 0;
    repeat (400) begin
      @(negedge clk_sys);
      if (hall_axis_sel === hsc_pkg::CHAN_Z) hits = 1;
    end
    check("scan reaches z", 16'h0001, 16'(hits));
    conclude();
  end
  // the tests take near 15250 cycles; this cuts a hang short
  initial begin
    repeat (40000) @(negedge clk_sys);
    err_total++;
    conclude();
  end
endmodule
